// *** hdl/adc_seq_pkg.sv ***
// shared constants and types for the serial converter sequencer
package adc_seq_pkg;

  // assignment word lengths per variant
  localparam logic [2:0] WORD_LEN_FOUR = 3'h3;
  localparam logic [2:0] WORD_LEN_EIGHT = 3'h4;

  // result width and bit counter end
  localparam int RESULT_BITS = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h8;
  localparam logic [7:0] TRIAL_MSB = 8'h80;

  // lsb-first readout index end
  localparam logic [2:0] LSB_IDX_LAST = 3'h7;

  // depth of the result buffer
  localparam int RESULT_BUF_DEPTH = 2;

  // reset values
  localparam logic [3:0] WORD_RESET = 4'h0;
  localparam logic [7:0] SAR_RESET = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SETTLE = 6'h04,
    ST_CONV = 6'h08,
    ST_LSB = 6'h10,
    ST_DONE = 6'h20
  } seq_state_t;

  // analog multiplexer steering
  typedef struct packed {
    logic differential;
    logic neg_shared;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
  } mux_sel_t;

  localparam mux_sel_t MUX_SEL_RESET = '{1'b0, 1'b0, 3'h0, 3'h0};

  // finished conversion as handed to the core side
  typedef struct packed {
    logic [2:0] pos_ch;
    logic [7:0] value;
  } result_t;

endpackage : adc_seq_pkg

// *** hdl/serial_adc_mux_sequencer.sv ***
// digital sequencer of a serial 8-bit converter with input multiplexer
`timescale 1ns/1ps

module serial_adc_mux_sequencer #(
  parameter bit EIGHT_INPUT = 1'b1,
  parameter int BUF_DEPTH = adc_seq_pkg::RESULT_BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic select_active_low,
  input wire logic serial_in,
  input wire logic lsb_order_strobe_n,
  input wire logic comp_above,
  input wire logic pos_below_neg,
  output logic [7:0] ladder_trial,
  output adc_seq_pkg::mux_sel_t mux_sel,
  output logic serial_out,
  output logic serial_out_oe,
  output logic conversion_active_flag,
  output logic conversion_active_oe,
  output adc_seq_pkg::result_t result_data,
  output logic result_valid,
  input wire logic result_ready
);

  localparam logic [2:0] WORD_LEN = EIGHT_INPUT ?
    adc_seq_pkg::WORD_LEN_EIGHT : adc_seq_pkg::WORD_LEN_FOUR;
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
  localparam logic [PTR_W:0] BUF_FULL = (PTR_W + 1)'(BUF_DEPTH);

  adc_seq_pkg::seq_state_t st_q, st_d;
  logic [3:0] word_q;
  logic [3:0] word_d;
  logic [2:0] acnt_q;
  logic [3:0] bcnt_q;
  logic [7:0] sar_q;
  logic [2:0] lidx_q;
  logic dout_q;
  logic doe_q;
  logic act_q;
  adc_seq_pkg::mux_sel_t mux_q;
  adc_seq_pkg::mux_sel_t mux_d;

  // state decode
  wire sel_clr = select_active_low;
  wire in_idle = (st_q == adc_seq_pkg::ST_IDLE);
  wire in_addr = (st_q == adc_seq_pkg::ST_ADDR);
  wire in_settle = (st_q == adc_seq_pkg::ST_SETTLE);
  wire in_conv = (st_q == adc_seq_pkg::ST_CONV);
  wire in_lsb = (st_q == adc_seq_pkg::ST_LSB);

  // addressing
  wire start_seen = in_idle & serial_in;
  wire addr_shift = in_addr & (acnt_q < WORD_LEN);
  wire addr_full = in_addr & (acnt_q >= WORD_LEN - 3'h1);
  wire buf_in_ready;
  // a full result buffer stalls the start, so no result is dropped
  wire go = addr_full & buf_in_ready;

  assign word_d = addr_shift ? {word_q[2:0], serial_in} : word_q;

  // word fields, first shifted bit is the mode bit
  wire w_sgl = EIGHT_INPUT ? word_d[3] : word_d[2];
  wire w_odd = EIGHT_INPUT ? word_d[2] : word_d[1];
  wire w_hi = EIGHT_INPUT ? word_d[1] : word_d[0];
  wire w_lo = EIGHT_INPUT ? word_d[0] : 1'b1;
  wire [1:0] w_pair = EIGHT_INPUT ? {w_hi, w_lo} : {1'b0, w_hi};

  always_comb begin
    mux_d.differential = ~w_sgl;
    mux_d.neg_shared = w_sgl & EIGHT_INPUT;
    mux_d.pos_ch = {w_pair, w_odd};
    mux_d.neg_ch = {w_pair, ~w_odd};
  end

  // successive approximation
  wire deciding = (in_settle | in_conv) &
    (bcnt_q < adc_seq_pkg::BIT_CNT_LAST);
  wire [7:0] trial_bit = adc_seq_pkg::TRIAL_MSB >> bcnt_q;
  // a reversed input pair can never beat the ladder
  wire bit_dec = comp_above & ~pos_below_neg;
  wire conv_end = in_conv & (bcnt_q == adc_seq_pkg::BIT_CNT_LAST);
  wire [2:0] shown_idx = 3'(adc_seq_pkg::BIT_CNT_LAST - bcnt_q);

  // lsb-first readout; four-input shares bit 0 with the msb stream
  wire lsb_adv = EIGHT_INPUT ? (in_lsb & ~lsb_order_strobe_n) :
    (in_lsb | conv_end);
  wire lsb_end = in_lsb & lsb_adv & (lidx_q == adc_seq_pkg::LSB_IDX_LAST);
  wire [2:0] lidx_nx = lidx_q + 3'h1;

  always_comb begin
    st_d = st_q;
    case (st_q)
      adc_seq_pkg::ST_IDLE: begin
        if (start_seen) st_d = adc_seq_pkg::ST_ADDR;
      end
      adc_seq_pkg::ST_ADDR: begin
        if (go) st_d = adc_seq_pkg::ST_SETTLE;
      end
      adc_seq_pkg::ST_SETTLE: begin
        st_d = adc_seq_pkg::ST_CONV;
      end
      adc_seq_pkg::ST_CONV: begin
        if (conv_end) st_d = adc_seq_pkg::ST_LSB;
      end
      adc_seq_pkg::ST_LSB: begin
        if (lsb_end) st_d = adc_seq_pkg::ST_DONE;
      end
      adc_seq_pkg::ST_DONE: begin
        st_d = adc_seq_pkg::ST_DONE;
      end
      default: begin
        st_d = adc_seq_pkg::ST_IDLE;
      end
    endcase
  end

  // deselect clears everything on the serial side
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= adc_seq_pkg::ST_IDLE;
    end else if (sel_clr) begin
      st_q <= adc_seq_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word_q <= adc_seq_pkg::WORD_RESET;
      acnt_q <= 3'h0;
    end else if (sel_clr || in_idle) begin
      word_q <= adc_seq_pkg::WORD_RESET;
      acnt_q <= 3'h0;
    end else if (addr_shift) begin
      word_q <= word_d;
      acnt_q <= acnt_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mux_q <= adc_seq_pkg::MUX_SEL_RESET;
      act_q <= 1'b0;
    end else if (sel_clr) begin
      mux_q <= adc_seq_pkg::MUX_SEL_RESET;
      act_q <= 1'b0;
    end else if (go) begin
      mux_q <= mux_d;
      act_q <= 1'b1;
    end else if (conv_end) begin
      act_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sar_q <= adc_seq_pkg::SAR_RESET;
      bcnt_q <= 4'h0;
    end else if (sel_clr || go) begin
      sar_q <= adc_seq_pkg::SAR_RESET;
      bcnt_q <= 4'h0;
    end else if (deciding) begin
      sar_q <= bit_dec ? (sar_q | trial_bit) : sar_q;
      bcnt_q <= bcnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dout_q <= 1'b0;
      doe_q <= 1'b0;
      lidx_q <= 3'h0;
    end else if (sel_clr) begin
      dout_q <= 1'b0;
      doe_q <= 1'b0;
      lidx_q <= 3'h0;
    end else if (go) begin
      dout_q <= 1'b0;
      doe_q <= 1'b1;
      lidx_q <= 3'h0;
    end else if (deciding) begin
      dout_q <= bit_dec;
    end else if (lsb_end) begin
      dout_q <= 1'b0;
    end else if (lsb_adv) begin
      dout_q <= sar_q[lidx_nx];
      lidx_q <= lidx_nx;
    end
  end

  // two-entry result buffer toward the core side
  adc_seq_pkg::result_t buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wp_q;
  logic [PTR_W-1:0] rp_q;
  logic [PTR_W:0] cnt_q;
  wire push = conv_end & ~sel_clr;
  wire pop = result_valid & result_ready;
  wire [PTR_W-1:0] wp_nx = (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
  wire [PTR_W-1:0] rp_nx = (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;

  assign buf_in_ready = (cnt_q != BUF_FULL);
  assign result_valid = (cnt_q != '0);
  assign result_data = buf_mem[rp_q];

  always_ff @(posedge core_clk) begin
    if (push) buf_mem[wp_q] <= '{mux_q.pos_ch, sar_q};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_nx;
      if (pop) rp_q <= rp_nx;
      cnt_q <= cnt_q + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end

  // outputs
  assign ladder_trial = sar_q | trial_bit;
  assign mux_sel = mux_q;
  assign serial_out = dout_q;
  assign serial_out_oe = doe_q;
  assign conversion_active_flag = act_q;
  assign conversion_active_oe = ~select_active_low;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  start_to_addr_a: assert property (
    !select_active_low && in_idle && serial_in |=> in_addr)
    else $error("start bit not taken");

  input_frozen_a: assert property (
    act_q && !select_active_low |=> $stable(word_q))
    else $error("address register moved during conversion");

  settle_low_a: assert property (
    go && !select_active_low |=>
      serial_out_oe && !serial_out && conversion_active_flag && in_settle)
    else $error("settle bit missing");

  conv_length_a: assert property (
    (go && !select_active_low ##1 !select_active_low [*8]
      ##1 !select_active_low) |->
      conversion_active_flag ##1 !conversion_active_flag)
    else $error("conversion length wrong");

  msb_stream_a: assert property (
    in_conv |-> serial_out == sar_q[shown_idx])
    else $error("msb-first bit wrong");

  lsb_stream_a: assert property (
    in_lsb |-> serial_out == sar_q[lidx_q])
    else $error("lsb-first bit wrong");

  lsb_hold_a: assert property (
    EIGHT_INPUT && in_lsb && lsb_order_strobe_n && !select_active_low
      |=> $stable(serial_out) && $stable(lidx_q))
    else $error("lsb not held");

  deselect_clear_a: assert property (
    select_active_low |=>
      !serial_out_oe && in_idle && !conversion_active_flag && sar_q == '0)
    else $error("deselect did not clear");

  zero_result_a: assert property (
    pos_below_neg && deciding && !select_active_low |=> !serial_out)
    else $error("reversed inputs gave a one");

  pair_adjacent_a: assert property (
    act_q && mux_sel.differential |->
      mux_sel.pos_ch[2:1] == mux_sel.neg_ch[2:1] &&
      mux_sel.pos_ch[0] != mux_sel.neg_ch[0])
    else $error("differential pair not adjacent");

  shared_neg_a: assert property (
    act_q && !mux_sel.differential |-> mux_sel.neg_shared == EIGHT_INPUT)
    else $error("shared negative misused");

  four_range_a: assert property (
    !EIGHT_INPUT && act_q |-> !mux_sel.pos_ch[2] && !mux_sel.neg_ch[2])
    else $error("four-input channel out of range");

  stall_hold_a: assert property (
    addr_full && !buf_in_ready && !select_active_low |=>
      in_addr && !conversion_active_flag)
    else $error("start taken while buffer full");

  addr_released_a: assert property (
    in_addr |-> !serial_out_oe && !conversion_active_flag)
    else $error("output driven while addressing");

  mux_held_a: assert property (
    act_q && !select_active_low |=> $stable(mux_sel))
    else $error("channel changed during conversion");

  settle_trial_a: assert property (
    in_settle |-> ladder_trial == adc_seq_pkg::TRIAL_MSB)
    else $error("first trial is not the msb");

  result_push_a: assert property (
    conv_end && !select_active_low |=>
      result_valid && !conversion_active_flag)
    else $error("result not handed over");

  four_turn_a: assert property (
    !EIGHT_INPUT && conv_end && !select_active_low |=>
      in_lsb && serial_out == sar_q[1])
    else $error("lsb-first stream did not follow");

  conv_start_c: cover property (go && !select_active_low);
  lsb_hold_c: cover property (in_lsb && lsb_order_strobe_n);
  conv_done_c: cover property (conv_end && !select_active_low);
  lsb_done_c: cover property (lsb_end && !select_active_low);
  buf_stall_c: cover property (addr_full && !buf_in_ready);

endmodule : serial_adc_mux_sequencer

// *** test/host_model.sv ***
// host processor and comparator stand-in facing the sequencer
`timescale 1ns/1ps
module host_model #(
  parameter int WORD_BITS = 4
) (
  input wire logic core_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic conversion_active_flag,
  input wire adc_seq_pkg::mux_sel_t mux_sel,
  input wire logic [7:0] ladder_trial,
  output logic select_active_low,
  output logic serial_in,
  output logic lsb_order_strobe_n,
  output logic comp_above,
  output logic pos_below_neg
);
  logic [7:0] ana [8];
  logic [7:0] shared_negative_input;
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  logic [2:0] obs [18];
  adc_seq_pkg::mux_sel_t obs_mux;
  logic [2:0] rel;
  adc_seq_pkg::mux_sel_t rel_mux;

  // four-input single-ended measures against ground
  assign pos_v = ana[mux_sel.pos_ch];
  assign neg_v = mux_sel.neg_shared ? shared_negative_input :
    mux_sel.differential ? ana[mux_sel.neg_ch] : 8'h00;
  assign pos_below_neg = pos_v < neg_v;
  assign comp_above = 8'(pos_v - neg_v) >= ladder_trial;

  initial begin
    select_active_low = 1'b1;
    serial_in = 1'b0;
    lsb_order_strobe_n = 1'b1;
  end

  // lead lows, start, word, then n observed cycles, then deselect
  task automatic xfer(input logic [3:0] word, input int lead, input int n);
    int t0;
    int i;
    t0 = lead + 1 + WORD_BITS;
    for (i = 0; i < t0 + n; i++) begin
      @(negedge core_clk);
      if (i >= t0) begin
        obs[i-t0] = {serial_out, serial_out_oe, conversion_active_flag};
      end
      if (i == t0) obs_mux = mux_sel;
      select_active_low = 1'b0;
      if (i < lead) serial_in = 1'b0;
      else if (i == lead) serial_in = 1'b1;
      else if (i < t0) serial_in = word[t0-1-i];
      else serial_in = 1'($urandom);
      lsb_order_strobe_n = (i < t0 + 10);
    end
    @(negedge core_clk);
    select_active_low = 1'b1;
    lsb_order_strobe_n = 1'b1;
    serial_in = ~serial_in;
    @(negedge core_clk);
    rel = {serial_out, serial_out_oe, conversion_active_flag};
    rel_mux = mux_sel;
  endtask : xfer
endmodule : host_model

// *** test/serial_adc_mux_sequencer_bench.sv ***
// self-checking bench for the serial converter sequencer
`timescale 1ns/1ps
module serial_adc_mux_sequencer_bench;
  logic core_clk;
  logic rstn;
  logic select_active_low;
  logic serial_in;
  logic lsb_order_strobe_n;
  logic comp_above;
  logic pos_below_neg;
  logic [7:0] ladder_trial;
  adc_seq_pkg::mux_sel_t mux_sel;
  logic serial_out;
  logic serial_out_oe;
  logic conversion_active_flag;
  adc_seq_pkg::result_t result_data;
  logic result_valid;
  logic result_ready;
  int num_errors;
  int n_compared;
  int ready_mode;
  logic [10:0] exp_q [$];
  logic sel4;
  logic sin4;
  logic strobe4;
  logic comp4;
  logic below4;
  logic [7:0] ladder4;
  adc_seq_pkg::mux_sel_t mux4;
  logic so4;
  logic oe4;
  logic flag4;
  logic flag_oe;
  logic flag_oe4;
  adc_seq_pkg::result_t res4;
  logic valid4;
  logic [10:0] exp4_q [$];

  serial_adc_mux_sequencer #(.EIGHT_INPUT(1'b1), .BUF_DEPTH(2)) uut (
    .core_clk(core_clk), .rstn(rstn),
    .select_active_low(select_active_low), .serial_in(serial_in),
    .lsb_order_strobe_n(lsb_order_strobe_n), .comp_above(comp_above),
    .pos_below_neg(pos_below_neg), .ladder_trial(ladder_trial),
    .mux_sel(mux_sel), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .conversion_active_flag(conversion_active_flag),
    .conversion_active_oe(flag_oe), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready)
  );

  host_model host (
    .core_clk(core_clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .conversion_active_flag(conversion_active_flag), .mux_sel(mux_sel),
    .ladder_trial(ladder_trial), .select_active_low(select_active_low),
    .serial_in(serial_in), .lsb_order_strobe_n(lsb_order_strobe_n),
    .comp_above(comp_above), .pos_below_neg(pos_below_neg)
  );

  // four-input variant runs beside the eight-input one
  serial_adc_mux_sequencer #(.EIGHT_INPUT(1'b0), .BUF_DEPTH(2)) uut4 (
    .core_clk(core_clk), .rstn(rstn), .select_active_low(sel4),
    .serial_in(sin4), .lsb_order_strobe_n(strobe4), .comp_above(comp4),
    .pos_below_neg(below4), .ladder_trial(ladder4), .mux_sel(mux4),
    .serial_out(so4), .serial_out_oe(oe4), .conversion_active_flag(flag4),
    .conversion_active_oe(flag_oe4), .result_data(res4),
    .result_valid(valid4), .result_ready(result_ready)
  );

  host_model #(.WORD_BITS(3)) host4 (
    .core_clk(core_clk), .serial_out(so4), .serial_out_oe(oe4),
    .conversion_active_flag(flag4), .mux_sel(mux4), .ladder_trial(ladder4),
    .select_active_low(sel4), .serial_in(sin4),
    .lsb_order_strobe_n(strobe4), .comp_above(comp4),
    .pos_below_neg(below4)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ready picked at the falling edge; the head is checked when it will pop
  always @(negedge core_clk) begin
    result_ready = (ready_mode == 2) | (ready_mode == 1 & 1'($urandom));
    if (result_valid === 1'b1 && result_ready) begin
      check("result", result_data,
            exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    if (valid4 === 1'b1 && result_ready) begin
      check("result4", res4,
            exp4_q.size() > 0 ? exp4_q.pop_front() : 'x);
    end
  end

  // the flag pin drives only while selected; select is steady here
  always @(posedge core_clk) begin
    if (rstn === 1'b1) begin
      check("flag oe", {flag_oe, flag_oe4},
            {~select_active_low, ~sel4});
    end
  end

  // go: conversion must start; only full runs leave a buffered result
  task automatic run(input logic [3:0] w, input int n, input bit go);
    logic [2:0] p;
    logic [7:0] pv;
    logic [7:0] nv;
    logic [7:0] v;
    logic b;
    int k;
    for (k = 0; k < 8; k++) host.ana[k] = 8'($urandom);
    host.shared_negative_input = 8'($urandom);
    p = {w[1:0], w[2]};
    pv = host.ana[p];
    nv = w[3] ? host.shared_negative_input : host.ana[{w[1:0], ~w[2]}];
    v = (pv < nv) ? 8'h00 : 8'(pv - nv);
    if (go && n == 18) exp_q.push_back({p, v});
    host.xfer(w, $urandom_range(2), n);
    for (k = 0; k < n; k++) begin
      b = k == 0 ? 1'b0 : k < 9 ? v[8-k] : k < 11 ? v[0] : v[k-10];
      check("link", go ? host.obs[k] : host.obs[k] & 3'h3,
            go ? {b, 1'b1, 1'(k < 9)} : 3'h0);
    end
    if (go) begin
      check("pos", host.obs_mux.pos_ch, p);
      check("mode", {host.obs_mux.differential, host.obs_mux.neg_shared},
            {~w[3], w[3]});
      if (!w[3]) check("neg", host.obs_mux.neg_ch, {w[1:0], ~w[2]});
    end
    check("release", {host.rel[1:0], host.rel_mux}, 10'h0);
  endtask : run

  // four-input: word is mode, polarity, pair; bit 0 shared by both streams
  task automatic run4(input logic [3:0] w);
    logic [2:0] p;
    logic [7:0] pv;
    logic [7:0] nv;
    logic [7:0] v;
    logic b;
    int k;
    for (k = 0; k < 8; k++) host4.ana[k] = 8'($urandom);
    p = {1'b0, w[0], w[1]};
    pv = host4.ana[p];
    nv = w[2] ? 8'h00 : host4.ana[{1'b0, w[0], ~w[1]}];
    v = (pv < nv) ? 8'h00 : 8'(pv - nv);
    exp4_q.push_back({p, v});
    host4.xfer(w, $urandom_range(2), 18);
    for (k = 0; k < 18; k++) begin
      b = k == 0 ? 1'b0 : k < 9 ? v[8-k] : k < 16 ? v[k-8] : 1'b0;
      check("link4", host4.obs[k], {b, 1'b1, 1'(k < 9)});
    end
    check("pos4", host4.obs_mux.pos_ch, p);
    check("mode4", {host4.obs_mux.differential, host4.obs_mux.neg_shared},
          {~w[2], 1'b0});
    if (!w[2]) check("neg4", host4.obs_mux.neg_ch, {1'b0, w[0], ~w[1]});
    check("release4", {host4.rel[1:0], host4.rel_mux}, 10'h0);
  endtask : run4

  initial begin
    int w;
    rstn = 1'b0;
    result_ready = 1'b0;
    ready_mode = 0;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(32'h74A0DF00));
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    ready_mode = 1;
    for (w = 0; w < 16; w++) run(w[3:0], 18, 1'b1);
    for (w = 0; w < 8; w++) run4(w[3:0]);
    ready_mode = 2;
    repeat (4) @(negedge core_clk);
    // core side stalls so both entries fill and the third start waits
    ready_mode = 0;
    run(4'h9, 18, 1'b1);
    run(4'h6, 18, 1'b1);
    run(4'hC, 4, 1'b0);
    ready_mode = 2;
    repeat (6) @(negedge core_clk);
    check("drained", {result_valid | valid4,
          10'(exp_q.size() + exp4_q.size())}, 11'h0);
    ready_mode = 1;
    run(4'h3, 5, 1'b1);
    run(4'h5, 18, 1'b1);
    ready_mode = 2;
    repeat (6) @(negedge core_clk);
    check("drained", {result_valid | valid4,
          10'(exp_q.size() + exp4_q.size())}, 11'h0);
    finish_test();
  end

  // hang guard, far beyond the fewer than 800 cycles the tests need
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : serial_adc_mux_sequencer_bench
